// file: eeprom_pkg.sv
// constants, field layouts and state codes for the two-wire eeprom slave
// assumes a 200 MHz core clock; imported by every design file
package eeprom_pkg;

    // ************************************************************
    // memory organisation
    // ************************************************************
    localparam int ADDR_W     = 11;
    localparam int DATA_W     = 8;
    localparam int MEM_WORDS  = 2048;
    localparam int SLOT_W     = 4;
    localparam int PAGE_SLOTS = 16;
    localparam int PAGE_W     = ADDR_W - SLOT_W;

    // ************************************************************
    // control byte layout
    // ************************************************************
    localparam int TYPE_W       = 4;
    localparam int BLK_W        = 3;
    localparam int CTL_TYPE_MSB = 7;
    localparam int CTL_BLK_MSB  = 3;
    localparam int CTL_RW_BIT   = 0;
    localparam int MSB_BIT      = 7;
    localparam int NEXT_BIT     = 6;
    // arbitrary value, set per system through the top parameter
    localparam logic [TYPE_W-1:0] DEV_TYPE_DFLT = 4'h5;

    // ************************************************************
    // bit counting and timing
    // ************************************************************
    localparam int          CNT_W     = 4;
    localparam logic [3:0]  BYTE_BITS = 4'h8;
    localparam logic [3:0]  FIRST_BIT = 4'h1;
    localparam int          CLK_MHZ   = 200;
    localparam int          TWR_US    = 10000;
    localparam int unsigned WR_CYCLES_DFLT = TWR_US * CLK_MHZ;
    localparam int          TIMER_W   = 22;

    // ************************************************************
    // state codes
    // ************************************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_MACK = 5'h10
    } bus_state_e;

    typedef enum logic [2:0] {
        PH_CTRL = 3'h1,
        PH_ADDR = 3'h2,
        PH_DATA = 3'h4
    } byte_phase_e;

endpackage : eeprom_pkg

// file: eeprom_mem_if.sv
// carrier between the protocol core and the storage array
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface eeprom_mem_if;
    import eeprom_pkg::*;

    logic                we;
    logic [ADDR_W-1:0]   waddr;
    logic [DATA_W-1:0]   wdata;
    logic [ADDR_W-1:0]   raddr;
    logic [DATA_W-1:0]   rdata;

    modport ctrl  (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);

endinterface : eeprom_mem_if

// file: eeprom_array.sv
// byte storage array with one write port and a registered read port
// assumes the caller holds raddr steady while it waits for rdata
`timescale 1ns/1ps
module eeprom_array
    import eeprom_pkg::*;
(
    input  wire logic          ref_clk_i,
    input  wire logic          resetn_i,
    input  wire logic          ce_i,
    eeprom_mem_if.store        mem
);

    logic [DATA_W-1:0] cells [MEM_WORDS];
    logic [DATA_W-1:0] rdata_ff;

    always_ff @(posedge ref_clk_i)
    begin
        if (ce_i && mem.we)
        begin
            cells[mem.waddr] <= mem.wdata;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_ff <= '0;
        end
        else if (ce_i)
        begin
            rdata_ff <= cells[mem.raddr];
        end
    end

    assign mem.rdata = rdata_ff;

endmodule : eeprom_array

// file: serial_eeprom_2wire_slave.sv
// slave side of a two-wire serial eeprom: framing, addressing, page buffer,
// self-timed write cycle and reads
// assumes scl, sda and write-protect arrive from pins outside the clock domain
//
// Notes on behaviour
// (R01) bus idle only when both lines high
// (R02) master starts only on an idle bus
// (R03) sda falling with scl high is start
// (R04) sda rising with scl high is stop
// (R05) master opens with start, closes with stop
// (R06) sda stable while scl high; one pulse per bit
// (R07) overflow keeps newest sixteen bytes, oldest replaced
// (R08) receiver acknowledges each byte on ninth clock
// (R09) acknowledge holds sda low through clock high
// (R10) no acknowledge while programming is busy
// (R11) master nack ends read; release sda
// (R12) control byte: type, block bits, direction
// (R13) direction one reads, zero writes
// (R14) acknowledge control byte only on type match
// (R15) byte write: control, address, data, stop
// (R16) page buffer committed by self-timed cycle after stop
// (R17) data bytes bump low four address bits only
// (R18) busy device nacks write control polling
// (R19) write-protect high inhibits all programming
// (R20) pointer holds last address plus one
// (R21) read control byte: acknowledge then shift data out
// (R22) repeated start after address keeps pointer, no program
// (R23) master ack fetches next byte, pointer plus one
// (R24) start or stop mid-byte aborts, partial byte dropped
// (R25) sda open-drain low only; sample on scl rise
`timescale 1ns/1ps
module serial_eeprom_2wire_slave
    import eeprom_pkg::*;
#(
    parameter logic [eeprom_pkg::TYPE_W-1:0] DEV_TYPE  = eeprom_pkg::DEV_TYPE_DFLT,
    parameter int unsigned                   WR_CYCLES = eeprom_pkg::WR_CYCLES_DFLT
)
(
    input  wire logic   ref_clk_i,
    input  wire logic   resetn_i,
    input  wire logic   ce_i,
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    input  wire logic   wp_i,
    output logic        sda_o,
    output logic        sda_oe_o,
    output logic        busy_o
);
    import eeprom_pkg::*;

    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        logic                               scl_m;
        logic                               scl_s;
        logic                               scl_p;
        logic                               sda_m;
        logic                               sda_s;
        logic                               sda_p;
        logic                               wp_m;
        logic                               wp_s;
        bus_state_e                         st;
        byte_phase_e                        ph;
        logic                               rw;
        logic                               mack;
        logic [CNT_W-1:0]                   cnt;
        logic [DATA_W-1:0]                  sh;
        logic [ADDR_W-1:0]                  ptr;
        logic [PAGE_SLOTS-1:0][DATA_W-1:0]  pbuf;
        logic [PAGE_SLOTS-1:0]              pvld;
        logic                               busy;
        logic [TIMER_W-1:0]                 tmr;
        logic [PAGE_W-1:0]                  cpage;
        logic                               sda_oe;
        logic                               sda_out;
    } core_s;

    localparam core_s CORE_RST = '{
        scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
        sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
        st: ST_IDLE, ph: PH_CTRL,
        default: '0
    };

    core_s r_ff;
    core_s nxt_r;

    eeprom_mem_if mem ();

    eeprom_array u_array (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .mem       (mem.store)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
        page_inc = {a[ADDR_W-1:SLOT_W], a[SLOT_W-1:0] + 4'h1};
    endfunction : page_inc

    // put the fetched byte on the wire, msb first
    function automatic core_s load_tx(input core_s s, input logic [DATA_W-1:0] d);
        core_s t;
        t        = s;
        t.sh     = d;
        t.sda_oe = ~d[MSB_BIT];
        t.cnt    = FIRST_BIT;
        t.st     = ST_TX;
        t.ptr    = s.ptr + 11'h001;
        load_tx  = t;
    endfunction : load_tx

    // ************************************************************
    // line events
    // ************************************************************
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_done;
    logic type_ok;

    assign scl_rise  = r_ff.scl_s && !r_ff.scl_p;                             // R25
    assign scl_fall  = !r_ff.scl_s && r_ff.scl_p;
    // both lines were high before the fall, so the bus was idle or held
    assign start_det = r_ff.scl_s && r_ff.scl_p && r_ff.sda_p && !r_ff.sda_s; // R01 R03
    assign stop_det  = r_ff.scl_s && r_ff.scl_p && !r_ff.sda_p && r_ff.sda_s; // R04
    assign byte_done = (r_ff.st == ST_RX) && scl_fall && (r_ff.cnt == BYTE_BITS);
    assign type_ok   = (r_ff.sh[CTL_TYPE_MSB -: TYPE_W] == DEV_TYPE);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        nxt_r       = r_ff;
        nxt_r.scl_m = scl_i;
        nxt_r.scl_s = r_ff.scl_m;
        nxt_r.scl_p = r_ff.scl_s;
        nxt_r.sda_m = sda_i;
        nxt_r.sda_s = r_ff.sda_m;
        nxt_r.sda_p = r_ff.sda_s;
        nxt_r.wp_m  = wp_i;
        nxt_r.wp_s  = r_ff.wp_m;
        nxt_r.sda_out = 1'b0;                                                  // R25

        // self-timed write cycle
        if (r_ff.busy)
        begin
            if (r_ff.tmr == TIMER_W'(WR_CYCLES - 1))
            begin
                nxt_r.busy = 1'b0;
                nxt_r.pvld = '0;
                nxt_r.tmr  = '0;
            end
            else
            begin
                nxt_r.tmr = r_ff.tmr + 22'h000001;
            end
        end

        case (r_ff.st)
            ST_IDLE:
            begin
                nxt_r.sda_oe = 1'b0;
            end
            ST_RX:
            begin
                if (scl_rise)
                begin
                    nxt_r.sh  = {r_ff.sh[NEXT_BIT:0], r_ff.sda_s};             // R06
                    nxt_r.cnt = r_ff.cnt + 4'h1;
                end
                else if (byte_done)
                begin
                    nxt_r.cnt = '0;
                    case (r_ff.ph)
                        PH_CTRL:
                        begin
                            if (type_ok && !r_ff.busy)                         // R10 R14 R18
                            begin
                                nxt_r.st     = ST_ACK;                         // R08
                                nxt_r.sda_oe = 1'b1;                           // R09
                                nxt_r.rw     = r_ff.sh[CTL_RW_BIT];            // R13
                                // block bits are the top of the word address
                                nxt_r.ptr[ADDR_W-1 -: BLK_W] = r_ff.sh[CTL_BLK_MSB -: BLK_W]; // R12
                                nxt_r.ph     = r_ff.sh[CTL_RW_BIT] ? PH_CTRL : PH_ADDR;
                            end
                            else
                            begin
                                nxt_r.st = ST_IDLE;
                            end
                        end
                        PH_ADDR:
                        begin
                            nxt_r.ptr[DATA_W-1:0] = r_ff.sh;                  // R15
                            nxt_r.ph     = PH_DATA;
                            nxt_r.st     = ST_ACK;
                            nxt_r.sda_oe = 1'b1;
                        end
                        PH_DATA:
                        begin
                            // slot follows the low pointer bits, so overflow
                            // overwrites the oldest bytes
                            nxt_r.pbuf[r_ff.ptr[SLOT_W-1:0]] = r_ff.sh;        // R07 R16
                            nxt_r.pvld[r_ff.ptr[SLOT_W-1:0]] = 1'b1;
                            nxt_r.ptr    = page_inc(r_ff.ptr);                 // R17
                            nxt_r.st     = ST_ACK;
                            nxt_r.sda_oe = 1'b1;
                        end
                        default:
                        begin
                            nxt_r.st = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_ACK:
            begin
                if (scl_fall)
                begin
                    if (r_ff.rw)
                    begin
                        nxt_r = load_tx(nxt_r, mem.rdata);                     // R20 R21
                    end
                    else
                    begin
                        nxt_r.sda_oe = 1'b0;
                        nxt_r.st     = ST_RX;
                    end
                end
            end
            ST_TX:
            begin
                if (scl_fall)
                begin
                    if (r_ff.cnt == BYTE_BITS)
                    begin
                        nxt_r.sda_oe = 1'b0;
                        nxt_r.mack   = 1'b0;
                        nxt_r.st     = ST_MACK;
                    end
                    else
                    begin
                        nxt_r.sh     = {r_ff.sh[NEXT_BIT:0], 1'b0};
                        nxt_r.sda_oe = ~r_ff.sh[NEXT_BIT];                     // R06
                        nxt_r.cnt    = r_ff.cnt + 4'h1;
                    end
                end
            end
            ST_MACK:
            begin
                nxt_r.sda_oe = 1'b0;                                           // R11
                if (scl_rise)
                begin
                    nxt_r.mack = ~r_ff.sda_s;
                end
                else if (scl_fall)
                begin
                    if (r_ff.mack)
                    begin
                        nxt_r = load_tx(nxt_r, mem.rdata);                     // R23
                    end
                    else
                    begin
                        nxt_r.st = ST_IDLE;                                    // R11
                    end
                end
            end
            default:
            begin
                nxt_r.st     = ST_IDLE;
                nxt_r.sda_oe = 1'b0;
            end
        endcase

        // conditions override any byte in flight
        if (start_det)
        begin
            nxt_r.st     = ST_RX;                                              // R24
            nxt_r.ph     = PH_CTRL;
            nxt_r.cnt    = '0;
            nxt_r.sda_oe = 1'b0;
            if (!r_ff.busy)
            begin
                nxt_r.pvld = '0;                                               // R22
            end
        end
        else if (stop_det)
        begin
            nxt_r.st     = ST_IDLE;                                            // R24
            nxt_r.ph     = PH_CTRL;
            nxt_r.cnt    = '0;
            nxt_r.sda_oe = 1'b0;
            if ((r_ff.ph == PH_DATA) && (|r_ff.pvld) && !r_ff.busy)
            begin
                if (r_ff.wp_s)
                begin
                    nxt_r.pvld = '0;                                           // R19
                end
                else
                begin
                    nxt_r.busy  = 1'b1;                                        // R16
                    nxt_r.tmr   = '0;
                    nxt_r.cpage = r_ff.ptr[ADDR_W-1:SLOT_W];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            r_ff <= CORE_RST;
        end
        else if (ce_i)
        begin
            r_ff <= nxt_r;
        end
    end

    // ************************************************************
    // array ports and outputs
    // ************************************************************
    // first sixteen cycles of the write cycle copy the buffer into the page
    assign mem.we    = r_ff.busy && (r_ff.tmr < TIMER_W'(PAGE_SLOTS))
                       && r_ff.pvld[r_ff.tmr[SLOT_W-1:0]] && !r_ff.wp_s;      // R19
    assign mem.waddr = {r_ff.cpage, r_ff.tmr[SLOT_W-1:0]};
    assign mem.wdata = r_ff.pbuf[r_ff.tmr[SLOT_W-1:0]];
    assign mem.raddr = r_ff.ptr;

    assign sda_o    = r_ff.sda_out;
    assign sda_oe_o = r_ff.sda_oe;
    assign busy_o   = r_ff.busy;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_rx_fresh;
        (r_ff.st == ST_RX) && (r_ff.cnt == '0) && (r_ff.ph == PH_CTRL);
    endsequence

    sequence s_busy_hold;
        r_ff.busy [*8];
    endsequence

    property p_start_seen;
        ce_i && start_det |=> s_rx_fresh;
    endproperty
    a_start_seen: assert property (p_start_seen) else $error("start not taken"); // R03

    property p_stop_seen;
        ce_i && stop_det |=> (r_ff.st == ST_IDLE) && !r_ff.sda_oe;
    endproperty
    a_stop_seen: assert property (p_stop_seen) else $error("stop not taken"); // R04

    property p_ack_low;
        (r_ff.st == ST_ACK) |-> r_ff.sda_oe && !sda_o;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack not driven low"); // R09

    property p_busy_nack;
        ce_i && byte_done && (r_ff.ph == PH_CTRL) && r_ff.busy && !start_det && !stop_det
            |=> (r_ff.st == ST_IDLE) && !r_ff.sda_oe;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("ack while busy"); // R10

    property p_type_miss;
        ce_i && byte_done && (r_ff.ph == PH_CTRL) && !type_ok && !start_det && !stop_det
            |=> (r_ff.st == ST_IDLE);
    endproperty
    a_type_miss: assert property (p_type_miss) else $error("foreign type acked"); // R14

    property p_page_wrap;
        ce_i && byte_done && (r_ff.ph == PH_DATA) && !start_det && !stop_det
            |=> (r_ff.ptr[SLOT_W-1:0] == $past(r_ff.ptr[SLOT_W-1:0]) + 4'h1)
                && (r_ff.ptr[ADDR_W-1:SLOT_W] == $past(r_ff.ptr[ADDR_W-1:SLOT_W]));
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("pointer left page"); // R17

    property p_commit_on_stop;
        ce_i && stop_det && (r_ff.ph == PH_DATA) && (|r_ff.pvld) && !r_ff.busy && !r_ff.wp_s
            |=> s_busy_hold;
    endproperty
    a_commit_on_stop: assert property (p_commit_on_stop) else $error("no write cycle"); // R16

    property p_wp_no_write;
        r_ff.wp_s |-> !mem.we;
    endproperty
    a_wp_no_write: assert property (p_wp_no_write) else $error("write under protect"); // R19

    property p_mack_release;
        (r_ff.st == ST_MACK) |-> !sda_oe_o;
    endproperty
    a_mack_release: assert property (p_mack_release) else $error("sda held in ack slot"); // R11

    property p_tx_stable;
        (r_ff.st == ST_TX) && r_ff.scl_s && r_ff.scl_p |-> $stable(r_ff.sda_oe);
    endproperty
    a_tx_stable: assert property (p_tx_stable) else $error("sda moved with scl high"); // R06

    property p_read_incr;
        ce_i && scl_fall && r_ff.rw && (r_ff.st == ST_ACK) && !start_det && !stop_det
            |=> (r_ff.ptr == $past(r_ff.ptr) + 11'h001) && (r_ff.st == ST_TX);
    endproperty
    a_read_incr: assert property (p_read_incr) else $error("read pointer not bumped"); // R20

    property p_low_only;
        sda_o == 1'b0;
    endproperty
    a_low_only: assert property (p_low_only) else $error("sda driven high"); // R25

endmodule : serial_eeprom_2wire_slave

// file: i2c_master_model.sv
// two-wire bus master model: drives scl and pulls the data wire low
// assumes a pull-up on the data wire; pacing taken from the core clock
`timescale 1ns/1ps
module i2c_master_model
(
    input  wire logic ref_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      pull_o
);
    // ************************************************************
    // idle bus, both lines high
    // ************************************************************
    initial
    begin
        scl_o  = 1'b1;
        pull_o = 1'b0;
    end

    // ************************************************************
    // bus primitives
    // ************************************************************
    task automatic wq(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : wq

    // one scl pulse, data changed only while scl low
    task automatic bit_io(input logic b, output logic r);
        scl_o = 1'b0;
        wq(6);
        pull_o = ~b;
        wq(6);
        scl_o = 1'b1;
        wq(6);
        r = sda_i;
        wq(7);
    endtask : bit_io

    task automatic start();
        scl_o = 1'b0;
        wq(6);
        pull_o = 1'b0;
        wq(6);
        scl_o = 1'b1;
        wq(6);
        pull_o = 1'b1;
        wq(6);
    endtask : start

    task automatic stop();
        scl_o = 1'b0;
        wq(6);
        pull_o = 1'b1;
        wq(6);
        scl_o = 1'b1;
        wq(6);
        pull_o = 1'b0;
        wq(12);
    endtask : stop

    // eight bits msb first plus the ninth acknowledge pulse
    task automatic xfer(input logic [7:0] tx, input logic nin, output logic [7:0] rx,
                        output logic nin_rx);
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(nin, nin_rx);
    endtask : xfer
endmodule : i2c_master_model

// file: serial_eeprom_2wire_slave_tb.sv
// self-checking bench for the two-wire eeprom slave
// assumes the master model file is compiled first
`timescale 1ns/1ps
module serial_eeprom_2wire_slave_tb;
    import eeprom_pkg::*;
    // arbitrary device-type code
    localparam logic [3:0] DEV_CODE = 4'h6;
    logic ref_clk = 1'b0;
    logic resetn  = 1'b0;
    logic wp      = 1'b0;
    logic ce      = 1'b1;
    logic scl, pull, sda_out, sda_oe, busy;
    logic ack;
    logic [7:0] rx;
    int err_count   = 0;
    int checks_done = 0;
    wire sda = ((sda_oe & ~sda_out) | pull) ? 1'b0 : 1'b1;

    always #2.5 ref_clk = ~ref_clk;

    serial_eeprom_2wire_slave #(.DEV_TYPE(DEV_CODE), .WR_CYCLES(1000)) uut
    (
        .ref_clk_i (ref_clk),
        .resetn_i  (resetn),
        .ce_i      (ce),
        .scl_i     (scl),
        .sda_i     (sda),
        .wp_i      (wp),
        .sda_o     (sda_out),
        .sda_oe_o  (sda_oe),
        .busy_o    (busy)
    );
    i2c_master_model m (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));

    // ************************************************************
    // compare and bus helpers
    // ************************************************************
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic wr_ctl(input logic [2:0] blk, input logic rw, output logic a);
        logic n;
        m.start();
        m.xfer({DEV_CODE, blk, rw}, 1'b1, rx, n);
        a = ~n;
    endtask : wr_ctl

    task automatic send(input logic [7:0] d);
        logic n;
        m.xfer(d, 1'b1, rx, n);
        chk_bit("data ack", 1'b1, ~n);
    endtask : send

    task automatic set_ptr(input logic [10:0] adr);
        wr_ctl(adr[10:8], 1'b0, ack);
        chk_bit("ctrl ack", 1'b1, ack);
        send(adr[7:0]);
    endtask : set_ptr

    // read n bytes, master acks all but the last
    task automatic rd(input logic [2:0] blk, input int n, input logic [7:0] exp);
        logic x;
        wr_ctl(blk, 1'b1, ack);
        chk_bit("read ctrl ack", 1'b1, ack);
        for (int i = 0; i < n; i++)
        begin
            m.xfer(8'hff, (i == n - 1), rx, x);
            chk_byte("read data", exp + 8'(i), rx);
        end
        chk_bit("released after nack", 1'b0, sda_oe);
        m.stop();
    endtask : rd

    task automatic poll_done();
        repeat (12)
        begin
            wr_ctl(3'h0, 1'b0, ack);
            m.stop();
            if (ack)
                break;
        end
        chk_bit("poll ack", 1'b1, ack);
    endtask : poll_done

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_bad_type();
        logic n;
        m.start();
        m.xfer({DEV_CODE ^ 4'hf, 4'h0}, 1'b1, rx, n);
        chk_bit("wrong type ack", 1'b0, ~n);
        m.stop();
        $display("test bad_type done");
    endtask : t_bad_type

    task automatic t_page();
        set_ptr(11'h12e);
        for (int k = 0; k < 18; k++)
            send(8'h40 + 8'(k));
        m.stop();
        m.wq(8);
        chk_bit("busy after stop", 1'b1, busy);
        wr_ctl(3'h0, 1'b0, ack);
        chk_bit("busy poll ack", 1'b0, ack);
        m.stop();
        poll_done();
        $display("test page done");
    endtask : t_page

    task automatic t_reads();
        set_ptr(11'h120);
        rd(3'h1, 15, 8'h42);
        rd(3'h1, 1, 8'h51);
        $display("test reads done");
    endtask : t_reads

    task automatic t_byte();
        set_ptr(11'h7ff);
        send(8'h3c);
        m.stop();
        poll_done();
        set_ptr(11'h7ff);
        rd(3'h7, 1, 8'h3c);
        $display("test byte done");
    endtask : t_byte

    task automatic t_wp();
        wp = 1'b1;
        set_ptr(11'h120);
        send(8'h00);
        m.stop();
        m.wq(20);
        chk_bit("busy with wp", 1'b0, busy);
        wp = 1'b0;
        set_ptr(11'h120);
        rd(3'h1, 1, 8'h42);
        $display("test wp done");
    endtask : t_wp

    task automatic t_abort();
        logic x;
        set_ptr(11'h121);
        for (int i = 0; i < 4; i++)
            m.bit_io(1'b0, x);
        m.stop();
        m.wq(20);
        chk_bit("busy after abort", 1'b0, busy);
        set_ptr(11'h121);
        rd(3'h1, 1, 8'h43);
        $display("test abort done");
    endtask : t_abort

    // clock enable low must hold the write cycle where it stands
    task automatic t_freeze();
        set_ptr(11'h130);
        send(8'h5a);
        m.stop();
        m.wq(8);
        ce = 1'b0;
        m.wq(1200);
        chk_bit("busy frozen", 1'b1, busy);
        ce = 1'b1;
        poll_done();
        set_ptr(11'h130);
        rd(3'h1, 1, 8'h5a);
        $display("test freeze done");
    endtask : t_freeze

    // ************************************************************
    // run control
    // ************************************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (8) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        m.wq(8);
        chk_bit("idle release", 1'b0, sda_oe);
        t_bad_type();
        t_page();
        t_reads();
        t_byte();
        t_wp();
        t_abort();
        t_freeze();
        report_and_stop();
    end

    initial
    begin
        repeat (80000) @(posedge ref_clk);
        err_count++;
        report_and_stop();
    end
endmodule : serial_eeprom_2wire_slave_tb
